// [rtl/itw_timer.sv]
module itw_timer
	import itw_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       srst,
	input  wire logic       oscTick,
	input  wire logic       safetyFuse,
	input  wire logic       wdrStrobe,
	input  wire itw_bus_s   busReq,
	output logic      [7:0] rdData,
	output logic            prescalerTick,
	output logic            irqReq,
	output logic            sysResetReq,
	output logic            senseTick
);

	// interval tap per select-a code
	function automatic itw_tap_t ivTap(input logic [2:0] sel);
		case (sel)
			3'h0:    ivTap = 5'h02;                  // 8 cycles
			3'h1:    ivTap = 5'h04;                  // 32 cycles
			3'h2:    ivTap = 5'h06;                  // 128 cycles
			3'h3:    ivTap = 5'h09;                  // 1K cycles
			3'h4:    ivTap = 5'h0B;                  // 4K cycles
			3'h5:    ivTap = 5'h0E;                  // 32K cycles
			3'h6:    ivTap = 5'h11;                  // 256K cycles
			default: ivTap = 5'h13;                  // 1024K cycles
		endcase
	endfunction

	// watchdog tap per period code
	function automatic itw_tap_t wdTap(input logic [2:0] sel);
		case (sel)
			3'h0:    wdTap = 5'h09;                  // 1K cycles
			3'h1:    wdTap = 5'h0A;                  // 2K cycles
			3'h2:    wdTap = 5'h0B;                  // 4K cycles
			3'h3:    wdTap = 5'h0C;                  // 8K cycles
			3'h4:    wdTap = 5'h0E;                  // 32K cycles
			3'h5:    wdTap = 5'h0F;                  // 64K cycles
			3'h6:    wdTap = 5'h11;                  // 256K cycles
			default: wdTap = 5'h12;                  // 512K cycles
		endcase
	endfunction

	// sense tap per select-b code
	function automatic itw_tap_t senTap(input logic [2:0] sel);
		case (sel)
			3'h1:    senTap = 5'h0E;                 // 32K cycles
			3'h2:    senTap = 5'h0F;                 // 64K cycles
			3'h3:    senTap = 5'h10;                 // 128K cycles
			3'h4:    senTap = 5'h11;                 // 256K cycles
			3'h5:    senTap = 5'h12;                 // 512K cycles
			default: senTap = 5'h04;                 // 32 cycles, test use
		endcase
	endfunction

	// control registers
	itw_wdc_s   wdc_reg;                             // watchdog control state
	itw_wdc_s   wdc_next;
	logic [2:0] ceCnt_reg;                           // change window countdown
	logic [2:0] ceCnt_next;
	logic [2:0] pbs_reg;                             // select b
	logic [2:0] pbs_next;
	logic [2:0] pas_reg;                             // select a
	logic [2:0] pas_next;
	logic       ie_reg;                              // interval irq enable
	logic       ie_next;
	logic       rsBit_reg;                           // restart bit as read
	logic       rsBit_next;
	logic [2:0] rsCnt_reg;                           // restart bit countdown
	logic [2:0] rsCnt_next;
	logic       watchdog_reset_flag_reg;                            // watchdog reset flag
	logic       watchdog_reset_flag_next;
	logic       ivFlag_reg;                          // interval interrupt flag
	logic       ivFlag_next;
	logic       levelTwo_reg;                        // fuse caught at reset
	logic       levelTwo_next;

	// timing registers and outputs
	logic [2:0] wdCnt_reg;                           // watchdog counter
	logic [2:0] wdCnt_next;
	logic [7:0] rdData_reg;
	logic [7:0] rdData_next;
	logic       preTick_reg;
	logic       preTick_next;
	logic       irq_reg;
	logic       irq_next;
	logic       sysRst_reg;                          // also the block's chip reset
	logic       sysRst_next;
	logic       senTick_reg;
	logic       senTick_next;

	// decoded strobes and events
	logic                  chipRst;                  // power-on or watchdog reset
	logic                  wrWdc;
	logic                  wrItc;
	logic                  wrRst;
	logic                  wrIfr;
	logic                  divRestart;               // restart to divider
	logic                  timeout;                  // counter overflow this cycle
	logic                  ivTick;                   // interval clock period edge
	logic                  wdTick;                   // watchdog clock edge
	logic                  snTick;                   // sense clock edge
	logic [DIV_STAGES-1:0] tapRise;

	assign chipRst = srst | sysRst_reg;
	assign wrWdc   = busReq.wr && (busReq.addr == ADDR_WDC);
	assign wrItc   = busReq.wr && (busReq.addr == ADDR_ITC);
	assign wrRst   = busReq.wr && (busReq.addr == ADDR_RST);
	assign wrIfr   = busReq.wr && (busReq.addr == ADDR_IFR);

	// restart only honoured with the watchdog off
	assign divRestart = chipRst
		| (wrItc && busReq.wdata[ITC_RS_BIT] && !wdc_reg.en);

	// divider on the slow oscillator steps
	itw_divider uDiv (
		.clk_sys (clk_sys),
		.restart (divRestart),
		.oscTick (oscTick),
		.tapRise (tapRise)
	);

	// tap selection
	assign ivTick = tapRise[ivTap(pas_reg)];
	assign wdTick = tapRise[wdTap(wdc_reg.ps)];
	assign snTick = (pbs_reg != 3'h0) && (pbs_reg != 3'h7) && tapRise[senTap(pbs_reg)];

	// next state of control registers
	always_comb begin
		wdc_next      = wdc_reg;
		ceCnt_next    = ceCnt_reg;
		pbs_next      = pbs_reg;
		pas_next      = pas_reg;
		ie_next       = ie_reg;
		rsBit_next    = rsBit_reg;
		rsCnt_next    = rsCnt_reg;
		watchdog_reset_flag_next     = watchdog_reset_flag_reg;
		ivFlag_next   = ivFlag_reg;
		levelTwo_next = levelTwo_reg;

		// change window countdown
		if (ceCnt_reg != 3'h0) begin
			ceCnt_next = ceCnt_reg - 3'h1;
			if (ceCnt_reg == 3'h1) begin
				wdc_next.ce = 1'b0;
			end
		end

		// restart bit countdown
		if (rsCnt_reg != 3'h0) begin
			rsCnt_next = rsCnt_reg - 3'h1;
			if (rsCnt_reg == 3'h1) begin
				rsBit_next = 1'b0;
			end
		end

		// watchdog control write, judged against the old window
		if (wrWdc) begin
			wdc_next.ce = busReq.wdata[WDC_CE_BIT];
			ceCnt_next  = busReq.wdata[WDC_CE_BIT] ? HOLD_CYCLES : 3'h0;
			if (busReq.wdata[WDC_EN_BIT]) begin
				wdc_next.en = 1'b1;
			end else if (wdc_reg.ce && !levelTwo_reg) begin
				wdc_next.en = 1'b0;
			end
			if (wdc_reg.ce) begin
				wdc_next.ps = busReq.wdata[WDC_PS_LSB +: 3];
			end
		end

		// interval control write
		if (wrItc) begin
			pbs_next = busReq.wdata[ITC_PBS_LSB +: 3];
			pas_next = busReq.wdata[ITC_PAS_LSB +: 3];
			ie_next  = busReq.wdata[ITC_IE_BIT];
			if (busReq.wdata[ITC_RS_BIT]) begin
				rsBit_next = 1'b1;
				rsCnt_next = HOLD_CYCLES;
			end
		end

		// flag clears by writing zero; a time-out wins
		if (wrRst && !busReq.wdata[RST_WATCHDOG_RESET_FLAG_BIT]) begin
			watchdog_reset_flag_next = 1'b0;
		end
		if (timeout) begin
			watchdog_reset_flag_next = 1'b1;
		end

		// interval flag: write one clears, a new period wins
		if (wrIfr && busReq.wdata[IFR_FLAG_BIT]) begin
			ivFlag_next = 1'b0;
		end
		if (ivTick) begin
			ivFlag_next = 1'b1;
		end

		// reset flag and level two pin the enable high
		if (watchdog_reset_flag_reg || timeout || levelTwo_reg) begin
			wdc_next.en = 1'b1;
		end

		// watchdog reset: everything but flag and level two, enable forced high
		if (sysRst_reg) begin
			wdc_next.ce = 1'b0;
			wdc_next.ps = PS_RESET;
			ceCnt_next  = 3'h0;
			pbs_next    = PS_RESET;
			pas_next    = PS_RESET;
			ie_next     = 1'b0;
			rsBit_next  = 1'b0;
			rsCnt_next  = 3'h0;
			ivFlag_next = 1'b0;
			wdc_next.en = 1'b1;
		end

		// power-on reset, fuse picks the starting state
		if (srst) begin
			wdc_next      = '{ce: 1'b0, en: safetyFuse, ps: PS_RESET};
			ceCnt_next    = 3'h0;
			pbs_next      = PS_RESET;
			pas_next      = PS_RESET;
			ie_next       = 1'b0;
			rsBit_next    = 1'b0;
			rsCnt_next    = 3'h0;
			watchdog_reset_flag_next     = 1'b0;
			ivFlag_next   = 1'b0;
			levelTwo_next = safetyFuse;
		end
	end

	// control register stage
	always_ff @(posedge clk_sys) begin
		wdc_reg      <= wdc_next;
		ceCnt_reg    <= ceCnt_next;
		pbs_reg      <= pbs_next;
		pas_reg      <= pas_next;
		ie_reg       <= ie_next;
		rsBit_reg    <= rsBit_next;
		rsCnt_reg    <= rsCnt_next;
		watchdog_reset_flag_reg     <= watchdog_reset_flag_next;
		ivFlag_reg   <= ivFlag_next;
		levelTwo_reg <= levelTwo_next;
	end

	// next state of counter, outputs and read data
	always_comb begin
		wdCnt_next   = wdCnt_reg;
		timeout      = 1'b0;
		preTick_next = ivTick;
		senTick_next = snTick;
		irq_next     = ivFlag_reg && ie_reg;
		rdData_next  = RD_RESET;

		// watchdog counter
		if (chipRst || !wdc_reg.en) begin
			wdCnt_next = 3'h0;
		end else if (wdrStrobe) begin
			wdCnt_next = 3'h0;
		end else if (wdTick) begin
			if (wdCnt_reg == WD_CNT_MAX) begin
				timeout    = 1'b1;
				wdCnt_next = 3'h0;
			end else begin
				wdCnt_next = wdCnt_reg + 3'h1;
			end
		end
		sysRst_next = timeout;

		// read mux, unmapped indices read zero
		if (busReq.rd) begin
			case (busReq.addr)
				ADDR_WDC: begin
					rdData_next = {3'h0, wdc_reg.ce, wdc_reg.en, wdc_reg.ps};
				end
				ADDR_ITC: begin
					rdData_next = {pbs_reg, rsBit_reg, ie_reg, pas_reg};
				end
				ADDR_RST: begin
					rdData_next = 8'(watchdog_reset_flag_reg) << RST_WATCHDOG_RESET_FLAG_BIT;
				end
				ADDR_IFR: begin
					rdData_next = 8'(ivFlag_reg) << IFR_FLAG_BIT;
				end
				default: begin
					rdData_next = RD_RESET;
				end
			endcase
		end

		// outputs quiet under power-on reset
		if (srst) begin
			wdCnt_next   = 3'h0;
			timeout      = 1'b0;
			sysRst_next  = 1'b0;
			preTick_next = 1'b0;
			senTick_next = 1'b0;
			irq_next     = 1'b0;
			rdData_next  = RD_RESET;
		end
	end

	// counter and output stage
	always_ff @(posedge clk_sys) begin
		wdCnt_reg   <= wdCnt_next;
		rdData_reg  <= rdData_next;
		preTick_reg <= preTick_next;
		irq_reg     <= irq_next;
		sysRst_reg  <= sysRst_next;
		senTick_reg <= senTick_next;
	end

	// outputs straight from flip-flops
	assign rdData        = rdData_reg;
	assign prescalerTick = preTick_reg;
	assign irqReq        = irq_reg;
	assign sysResetReq   = sysRst_reg;
	assign senseTick     = senTick_reg;

endmodule

// [rtl/itw_pkg.sv]
// shared constants and carriers for the interval timer with watchdog
package itw_pkg;

	// slow oscillator and divider shape
	localparam int unsigned SLOW_OSC_HZ = 90000;     // nominal calibrated oscillator rate
	localparam int unsigned DIV_STAGES  = 20;        // ripple stages of the divider

	// register indices on the local port
	localparam logic [2:0] ADDR_WDC = 3'h0;          // watchdog_control
	localparam logic [2:0] ADDR_ITC = 3'h1;          // interval_timer_control
	localparam logic [2:0] ADDR_RST = 3'h2;          // reset_status_register
	localparam logic [2:0] ADDR_IFR = 3'h3;          // interval flag register

	// watchdog_control fields
	localparam int unsigned WDC_CE_BIT  = 4;         // change_enable_bit
	localparam int unsigned WDC_EN_BIT  = 3;         // watchdog_enable_bit
	localparam int unsigned WDC_PS_LSB  = 0;         // watchdog_period_select, 3 bits

	// interval_timer_control fields
	localparam int unsigned ITC_PBS_LSB = 5;         // interval_period_select_b, 3 bits
	localparam int unsigned ITC_RS_BIT  = 4;         // prescaler_restart_bit
	localparam int unsigned ITC_IE_BIT  = 3;         // interval_irq_enable
	localparam int unsigned ITC_PAS_LSB = 0;         // interval_period_select_a, 3 bits

	// status fields
	localparam int unsigned RST_WATCHDOG_RESET_FLAG_BIT = 3;        // watchdog_reset_flag
	localparam int unsigned IFR_FLAG_BIT = 0;        // interval interrupt flag

	// values after reset
	localparam logic [2:0] PS_RESET  = 3'h0;         // period selects after reset
	localparam logic [7:0] RD_RESET  = 8'h00;        // read data after reset

	// cycle counts
	localparam logic [2:0] HOLD_CYCLES = 3'h4;       // self-clearing bit lifetime
	localparam logic [2:0] WD_CNT_MAX  = 3'h7;       // last value before overflow

	// tap index into the divider
	typedef logic [4:0] itw_tap_t;

	// local register port request
	typedef struct packed {
		logic [2:0] addr;                            // register index
		logic [7:0] wdata;                           // write data
		logic       wr;                              // write strobe
		logic       rd;                              // read strobe
	} itw_bus_s;

	// watchdog control state
	typedef struct packed {
		logic       ce;                              // change window open
		logic       en;                              // watchdog running
		logic [2:0] ps;                              // period select
	} itw_wdc_s;

endpackage

// [rtl/itw_divider.sv]
// 20-stage ripple-equivalent divider stepped by the slow oscillator
module itw_divider
	import itw_pkg::*;
(
	input  wire logic                  clk_sys,
	input  wire logic                  restart,
	input  wire logic                  oscTick,
	output logic      [DIV_STAGES-1:0] tapRise
);

	logic [DIV_STAGES-1:0] cnt_reg;                  // divider stages
	logic [DIV_STAGES-1:0] cnt_next;                 // next stage values
	logic [DIV_STAGES-1:0] lowOnes;                  // all lower stages are one

	// rising edge of each stage, seen in the oscillator step that makes it, one clock ahead of the stage register
	genvar k;
	generate
		for (k = 0; k < DIV_STAGES; k++) begin : gTap
			if (k == 0) begin : gFirst
				assign lowOnes[k] = 1'b1;
			end else begin : gRest
				assign lowOnes[k] = lowOnes[k-1] & cnt_reg[k-1];
			end
			assign tapRise[k] = oscTick & ~restart & lowOnes[k] & ~cnt_reg[k];
		end
	endgenerate

	// free running count, cleared only by restart
	always_comb begin
		cnt_next = cnt_reg;
		if (restart) begin
			cnt_next = '0;
		end else if (oscTick) begin
			cnt_next = cnt_reg + DIV_STAGES'(1);
		end
	end

	// register stage
	always_ff @(posedge clk_sys) begin
		cnt_reg <= cnt_next;
	end

endmodule

// [sim/itw_timer_assertions.sv]
// watches the top ports of the interval timer with watchdog
module itw_timer_assertions
	import itw_pkg::*;
(
	input wire logic       clk_sys,
	input wire logic       srst,
	input wire logic       oscTick,
	input wire logic       wdrStrobe,
	input wire itw_bus_s   busReq,
	input wire logic [7:0] rdData,
	input wire logic       prescalerTick,
	input wire logic       irqReq,
	input wire logic       sysResetReq,
	input wire logic       senseTick
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);

	logic [15:0] oscCnt_reg;  // slow ticks since any reset, saturating
	logic [15:0] oscCnt_next; // next tick count

	// restart the count on either reset so a short time-out shows
	always_comb begin
		oscCnt_next = oscCnt_reg + {15'h0, oscTick && (oscCnt_reg != 16'hFFFF)};
		if (srst || sysResetReq) begin
			oscCnt_next = 16'h0;
		end
	end

	// register only
	always_ff @(posedge clk_sys) begin
		oscCnt_reg <= oscCnt_next;
	end

	a_resv_read_zero: assert property (
		$past(busReq.rd) && ($past(busReq.addr) == ADDR_WDC) |-> rdData[7:5] == 3'h0)
		else $error("reserved control bits read nonzero");
	a_wd_pulse_one: assert property (sysResetReq |=> !sysResetReq)
		else $error("time-out request longer than one cycle");
	a_wd_min_span: assert property (sysResetReq |-> oscCnt_reg >= 16'h1C00)
		else $error("time-out came before seven shortest periods");
	a_wdr_blocks_reset: assert property (wdrStrobe |=> !sysResetReq)
		else $error("time-out right after watchdog restart");
	a_irq_after_tick: assert property ($rose(irqReq) |-> $past(prescalerTick))
		else $error("interrupt rose without an interval tick");
	a_tick_from_osc: assert property (prescalerTick |-> $past(oscTick))
		else $error("interval tick without a slow tick");
	a_tick_one_cycle: assert property (prescalerTick |=> !prescalerTick)
		else $error("interval tick longer than one cycle");
	a_sense_from_osc: assert property (senseTick |-> $past(oscTick))
		else $error("sense tick without a slow tick");

	c_timeout: cover property (sysResetReq);
	c_irq: cover property ($rose(irqReq));
	c_wdr: cover property (wdrStrobe ##1 oscTick);
endmodule

bind itw_timer itw_timer_assertions i_itw_timer_assertions (.clk_sys, .srst, .oscTick,
	.wdrStrobe, .busReq, .rdData, .prescalerTick, .irqReq, .sysResetReq, .senseTick);

// [sim/itw_timer_tb.sv]
// self-checking bench for the interval timer with watchdog
module itw_timer_tb
	import itw_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic       clk_sys = 1'b0;   // 50 MHz
	logic       srst = 1'b1;      // held from time zero
	logic       oscTick = 1'b0;   // slow tick, every cycle when on
	logic       safetyFuse = 1'b0;
	logic       wdrStrobe = 1'b0;
	itw_bus_s   busReq = '0;
	logic [7:0] rdData;
	logic       prescalerTick, irqReq, sysResetReq, senseTick;
	logic [7:0] expQ[$];          // expected read data, oldest first
	logic       rdSeen = 1'b0;    // a read was taken last edge
	int         error_cnt = 0;
	int         checks = 0;
	int         rstCnt = 0;       // time-out requests seen
	int         n;
	int         nSense;           // sense ticks counted
	logic [7:0] v;

	always #10 clk_sys = ~clk_sys;

	itw_timer i_itw_timer (.clk_sys, .srst, .oscTick, .safetyFuse, .wdrStrobe, .busReq,
		.rdData, .prescalerTick, .irqReq, .sysResetReq, .senseTick);

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic summarize();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	// one-cycle write, gap cycle after
	task automatic bw(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		busReq <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_sys);
		busReq <= '0;
	endtask

	// one-cycle read, expectation queued for the monitor
	task automatic br(input logic [2:0] a, input logic [7:0] e);
		expQ.push_back(e);
		@(posedge clk_sys);
		busReq <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_sys);
		busReq <= '0;
	endtask

	// one-cycle watchdog restart pulse
	task automatic wdr();
		@(posedge clk_sys);
		wdrStrobe <= 1'b1;
		@(posedge clk_sys);
		wdrStrobe <= 1'b0;
	endtask

	task automatic doReset(input logic fuse);
		safetyFuse <= fuse;
		srst <= 1'b1;
		repeat (5) @(posedge clk_sys);
		srst <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	always @(posedge clk_sys) begin
		if (rdSeen) chk("rdData", expQ.pop_front(), rdData);
		rdSeen <= busReq.rd;
		if (sysResetReq) rstCnt++;
	end

	// hang guard
	initial begin
		repeat (40000) @(posedge clk_sys);
		error_cnt++;
		summarize();
	end

	initial begin
		n = $urandom(3);
		doReset(1'b0);
		for (int a = 0; a < 6; a++) br(3'(a), RD_RESET);
		$display("test reset values done");
		v = 8'($urandom) & 8'hEF;
		bw(ADDR_ITC, v);
		br(ADDR_ITC, v);
		bw(ADDR_ITC, 8'h00);
		$display("test interval control done");
		bw(ADDR_WDC, 8'hEB);
		br(ADDR_WDC, 8'h08);
		bw(ADDR_WDC, 8'h00);
		br(ADDR_WDC, 8'h08);
		bw(ADDR_WDC, 8'h18);
		br(ADDR_WDC, 8'h18);
		repeat (3) @(posedge clk_sys);
		br(ADDR_WDC, 8'h08);
		bw(ADDR_WDC, 8'h00);
		br(ADDR_WDC, 8'h08);
		wdr();
		bw(ADDR_WDC, 8'h18);
		bw(ADDR_WDC, 8'h0B);
		br(ADDR_WDC, 8'h0B);
		bw(ADDR_WDC, 8'h1B);
		bw(ADDR_WDC, 8'h00);
		br(ADDR_WDC, 8'h00);
		$display("test change window done");
		bw(ADDR_ITC, 8'h10);
		br(ADDR_ITC, 8'h10);
		repeat (4) @(posedge clk_sys);
		br(ADDR_ITC, 8'h00);
		$display("test restart bit done");
		oscTick <= 1'b1;
		bw(ADDR_ITC, 8'hC8);
		@(posedge clk_sys);
		n = 0;
		nSense = 0;
		repeat (96) begin
			@(negedge clk_sys);
			n += int'(prescalerTick);
			nSense += int'(senseTick);
		end
		chk("prescalerTick", 12, n);
		chk("senseTick", 3, nSense);
		chk("irqReq", 1, irqReq);
		br(ADDR_IFR, 8'h01);
		bw(ADDR_ITC, 8'h00);
		repeat (4) @(negedge clk_sys);
		chk("irqReq", 0, irqReq);
		oscTick <= 1'b0;
		repeat (2) @(posedge clk_sys);
		bw(ADDR_IFR, 8'h01);
		br(ADDR_IFR, 8'h00);
		oscTick <= 1'b1;
		$display("test interval irq done");
		bw(ADDR_WDC, 8'h08);
		n = 0;
		while (rstCnt == 0 && n < 12000) begin
			@(negedge clk_sys);
			n++;
		end
		chk("timeoutSpan", 1, n > 7168 && n <= 8200);
		br(ADDR_RST, 8'h08);
		br(ADDR_WDC, 8'h08);
		bw(ADDR_WDC, 8'h18);
		bw(ADDR_WDC, 8'h00);
		br(ADDR_WDC, 8'h08);
		bw(ADDR_RST, 8'h00);
		bw(ADDR_WDC, 8'h18);
		bw(ADDR_WDC, 8'h00);
		br(ADDR_WDC, 8'h00);
		$display("test time-out done");
		bw(ADDR_WDC, 8'h08);
		repeat (3) begin
			repeat (4000) @(posedge clk_sys);
			wdr();
		end
		chk("resetCount", 1, rstCnt);
		bw(ADDR_WDC, 8'h18);
		bw(ADDR_WDC, 8'h00);
		$display("test watchdog restart done");
		oscTick <= 1'b0;
		doReset(1'b1);
		br(ADDR_WDC, 8'h08);
		bw(ADDR_WDC, 8'h18);
		bw(ADDR_WDC, 8'h00);
		br(ADDR_WDC, 8'h08);
		wdr();
		bw(ADDR_WDC, 8'h18);
		bw(ADDR_WDC, 8'h0B);
		br(ADDR_WDC, 8'h0B);
		$display("test safety level two done");
		summarize();
	end
endmodule
